// [bench/card_model.sv]
// Behavioural card in the socket: pin levels and interrogation results.
`timescale 1ns/10ps
`default_nettype none
module card_model (
    input  wire logic  aclk,
    input  wire logic  insert,
    input  wire logic  retest_start,
    output logic [3:0] pins,
    output logic [6:0] found,
    output logic       busy,
    output logic       done
);
    // =========================================================
    // Interrogation
    logic [2:0] cnt_q = 3'h0;
    logic       ins_q = 1'h0;
    // Detect and status pins sit low with a card in; ready follows it.
    assign pins  = {!insert, !insert, insert, !insert};
    // A valid three-volt CardBus card.
    assign found = 7'h62;
    assign busy  = cnt_q != 3'h0;
    assign done  = cnt_q == 3'h1;
    // Case equality keeps an unreset pulse from poisoning the count.
    always @(posedge aclk) begin
        ins_q <= insert;
        cnt_q <= (insert && !ins_q) || retest_start === 1'h1 ? 3'h4
                 : cnt_q - {2'h0, busy};
    end
endmodule : card_model
`default_nettype wire

// [bench/test_sock_status_regs.sv]
// Self-checking bench of the socket status and force register block.
`timescale 1ns/10ps
`default_nettype none
module test_sock_status_regs
    import sock_stat_pkg::*;
;
    // =========================================================
    // Stimulus and checking
    logic             aclk = 1'h0, aresetn = 1'h0, ins = 1'h0;
    logic             grn = 1'h1, cp = 1'h1;
    logic [7:0]       aa = 8'h00, side = 8'h00;
    logic [3:0]       pv = 4'h0;
    logic [4:0]       v = 5'h00;
    logic [31:0]      wd = 32'h0, rd;
    logic [1:0]       resp, st;
    wire logic [2:0]  rdy;
    wire logic [1:0]  br, rr;
    wire logic [31:0] rdt;
    wire logic [3:0]  pins;
    wire logic [6:0]  fnd;
    wire logic        bv, rv, rts, pce, irq, busy, done;
    int               fail_count = 0, tests_run = 0;
    always #2 aclk = ~aclk;
    sock_status_regs dut_u (.aclk(aclk), .aresetn(aresetn),
        .global_reset_pin_n(grn), .bus_reset_pin_n(!side[7]),
        .s_awaddr(aa), .s_awvalid(v[4]), .s_awready(rdy[2]), .s_wdata(wd),
        .s_wstrb(4'hf), .s_wvalid(v[3]), .s_wready(rdy[1]), .s_bresp(br),
        .s_bvalid(bv), .s_bready(v[2]), .s_araddr(aa), .s_arvalid(v[1]),
        .s_arready(rdy[0]), .s_rdata(rdt), .s_rresp(rr), .s_rvalid(rv),
        .s_rready(v[0]), .detect_pin_a(pins[3]), .detect_pin_b(pins[2]),
        .card_ready_irq_pin(pins[1]), .status_change_pin(pins[0]),
        .interrogating(busy), .interrog_done(done), .interrog_valid(fnd[6]),
        .interrog_cardbus(fnd[5]), .interrog_legacy(fnd[4]),
        .interrog_volts(fnd[3:0]), .power_request(side[6]),
        .power_request_volts(pv), .power_done(side[5]),
        .power_on_result(1'h1), .card_removed(side[4]), .cycle_pending(cp),
        .detect_a_change(side[0]), .detect_b_change(side[1]),
        .status_change_edge(side[2]), .power_change(side[3]),
        .retest_start(rts), .power_ctl_enable(pce), .irq(irq));
    card_model card_u (.aclk(aclk), .insert(ins), .retest_start(rts),
        .pins(pins), .found(fnd), .busy(busy), .done(done));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) fail_count++;
        if (g !== e) $display("wrong value at %0t: %h, not %h", $time, g, e);
    endtask : chk
    // One AXI transfer; status outputs are sampled with the answer.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        logic [2:0] t;
        logic       tb;
        tb = 1'h0;
        {aa, wd} <= {a, d};
        v <= {w, w, w, !w, !w};
        while (!tb) begin
            @(negedge aclk);
            t = rdy;
            tb = (w ? bv : rv) === 1'h1;
            {rd, resp, st} = {rdt, w ? br : rr, pce, irq};
            @(posedge aclk);
            v <= v & ~{t[2:1], tb, t[0], tb};
        end
        @(posedge aclk);
    endtask : xfer
    task automatic rc(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hffff_ffff);
        xfer(1'h0, a, 32'h0);
        chk(rd & m, e);
    endtask : rc
    // Bit 7 drives the bus reset, the rest are side pulses; every bit lasts one cycle.
    task automatic pl(input logic [7:0] p);
        side <= p;
        @(posedge aclk) side <= 8'h00;
        @(posedge aclk);
    endtask : pl
    task automatic t_reset;
        rc(ADDR_PRESENT, 32'h7);
        chk({30'h0, st}, 32'h2);
        rc(8'h20, 32'h0);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        $display("reset test done");
    endtask : t_reset
    task automatic t_force;
        xfer(1'h1, ADDR_FORCE, 32'h3fbd);
        chk({30'h0, resp}, {30'h0, RESP_OKAY});
        pl(8'h01);
        rc(ADDR_PRESENT, 32'h3fb7);
        rc(ADDR_EVENT, 32'hf, 32'hf);
        rc(ADDR_FORCE, 32'h0);
        chk({30'h0, st}, 32'h0);
        xfer(1'h1, ADDR_IRQ_MASK, 32'h2);
        chk({30'h0, st}, 32'h1);
        xfer(1'h1, ADDR_EVENT, 32'h2);
        chk({30'h0, st}, 32'h0);
        $display("force test done");
    endtask : t_force
    task automatic t_card;
        ins <= 1'h1;
        xfer(1'h1, ADDR_FORCE, 32'h4000);
        repeat (8) @(posedge aclk);
        rc(ADDR_PRESENT, 32'h0860, 32'h3c77);
        chk({30'h0, st}, 32'h2);
        xfer(1'h1, ADDR_FORCE, 32'h000f);
        rc(ADDR_PRESENT, 32'h0040, 32'h004f);
        pv <= 4'h1;
        pl(8'h40);
        pl(8'h30);
        rc(ADDR_PRESENT, 32'h0328, 32'h0338);
        pv <= 4'h2;
        pl(8'h40);
        rc(ADDR_PRESENT, 32'h0, 32'h0200);
        $display("card test done");
    endtask : t_card
    task automatic t_ctx;
        pl(8'h80);
        cp <= 1'h0;
        pl(8'h10);
        cp <= 1'h1;
        rc(ADDR_PRESENT, 32'h0, 32'h0338);
        xfer(1'h1, ADDR_CONTROL, 32'h1);
        xfer(1'h1, ADDR_FORCE, 32'h0330);
        pl(8'h20);
        pl(8'h80);
        rc(ADDR_PRESENT, 32'h0338, 32'h0338);
        grn <= 1'h0;
        @(posedge aclk) grn <= 1'h1;
        rc(ADDR_PRESENT, 32'h0, 32'h0338);
        rc(ADDR_CONTROL, 32'h0);
        $display("context test done");
    endtask : t_ctx
    task automatic final_report;
        $display("compares %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    initial begin
        #20000 fail_count++;
        final_report;
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk) t_reset;
        t_force;
        t_card;
        t_ctx;
        final_report;
    end
endmodule : test_sock_status_regs
`default_nettype wire

// [logic/sock_axil_slave.sv]
// AXI4-Lite slave front end that turns write traffic into single-cycle strobes.
`timescale 1ns/10ps
`default_nettype none
module sock_axil_slave
    import sock_stat_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    output logic             wr_stb,
    output logic [7:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_ok,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_ok
);
    logic        aw_have_q;
    logic        w_have_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;

    // Address and data are taken independently; each is held until the other.
    assign s_awready = !aw_have_q && !s_bvalid;
    assign s_wready  = !w_have_q && !s_bvalid;
    assign wr_stb    = aw_have_q && w_have_q;
    assign wr_addr   = aw_addr_q;
    assign wr_data   = w_data_q;
    assign wr_strb   = w_strb_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            s_bvalid  <= 1'b0;
            s_bresp   <= RESP_OKAY;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_wdata;
                w_strb_q <= s_wstrb;
            end
            if (wr_stb) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                s_bvalid  <= 1'b1;
                s_bresp   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    assign s_arready = !s_rvalid;
    assign rd_addr   = s_araddr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h0000_0000;
            s_rresp  <= RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rdata  <= rd_ok ? rd_data : 32'h0000_0000;
            s_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
        end
    end
endmodule : sock_axil_slave
`default_nettype wire

// [logic/sock_stat_pkg.sv]
// Package of offsets, field positions and reset values for the socket status block.
package sock_stat_pkg;
    // ==========================================================================
    // Register byte addresses
    // ==========================================================================
    localparam logic [7:0] ADDR_EVENT    = 8'h00;
    localparam logic [7:0] ADDR_PRESENT  = 8'h08;
    localparam logic [7:0] ADDR_FORCE    = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h04;
    localparam logic [7:0] ADDR_CONTROL  = 8'h10;
    // ==========================================================================
    // Present-state and force field positions
    // ==========================================================================
    localparam int BIT_YV        = 13;
    localparam int BIT_XV        = 12;
    localparam int BIT_3V        = 11;
    localparam int BIT_5V        = 10;
    localparam int BIT_BADREQ    = 9;
    localparam int BIT_DATALOSS  = 8;
    localparam int BIT_UNRECOG   = 7;
    localparam int BIT_READY     = 6;
    localparam int BIT_CARDBUS   = 5;
    localparam int BIT_LEGACY    = 4;
    localparam int BIT_POWERED   = 3;
    localparam int BIT_DETECT_B  = 2;
    localparam int BIT_DETECT_A  = 1;
    localparam int BIT_STSCHG    = 0;
    localparam int BIT_RETEST    = 14;
    // Event register positions.
    localparam int EV_STSCHG     = 0;
    localparam int EV_DETECT_A   = 1;
    localparam int EV_DETECT_B   = 2;
    localparam int EV_POWER      = 3;
    // Control register position of the event signalling enable.
    localparam int CTL_PME_EN    = 0;
    // ==========================================================================
    // Reset values, masks and response codes
    // ==========================================================================
    localparam logic [31:0] FORCE_WMASK = 32'h0000_7fbf;
    localparam logic [3:0]  EVENT_RESET = 4'h0;
    localparam logic [3:0]  DETECT_RESET = 4'h3;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage : sock_stat_pkg

// [logic/sock_status_regs.sv]
// Socket present-state, force-event, event and mask registers of one socket.
`timescale 1ns/10ps
`default_nettype none
module sock_status_regs
    import sock_stat_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        global_reset_pin_n,
    input  wire logic        bus_reset_pin_n,
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    input  wire logic        detect_pin_a,
    input  wire logic        detect_pin_b,
    input  wire logic        card_ready_irq_pin,
    input  wire logic        status_change_pin,
    input  wire logic        interrogating,
    input  wire logic        interrog_done,
    input  wire logic        interrog_valid,
    input  wire logic        interrog_cardbus,
    input  wire logic        interrog_legacy,
    input  wire logic [3:0]  interrog_volts,
    input  wire logic        power_request,
    input  wire logic [3:0]  power_request_volts,
    input  wire logic        power_done,
    input  wire logic        power_on_result,
    input  wire logic        card_removed,
    input  wire logic        cycle_pending,
    input  wire logic        detect_a_change,
    input  wire logic        detect_b_change,
    input  wire logic        status_change_edge,
    input  wire logic        power_change,
    output logic             retest_start,
    output logic             power_ctl_enable,
    output logic             irq
);
    // ==========================================================================
    // Bus front end
    // ==========================================================================
    logic        wr_stb;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_ok;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_ok;

    sock_axil_slave u_bus (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .s_awaddr  (s_awaddr),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wdata   (s_wdata),
        .s_wstrb   (s_wstrb),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bresp   (s_bresp),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .s_araddr  (s_araddr),
        .s_arvalid (s_arvalid),
        .s_arready (s_arready),
        .s_rdata   (s_rdata),
        .s_rresp   (s_rresp),
        .s_rvalid  (s_rvalid),
        .s_rready  (s_rready),
        .wr_stb    (wr_stb),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data),
        .wr_strb   (wr_strb),
        .wr_ok     (wr_ok),
        .rd_addr   (rd_addr),
        .rd_data   (rd_data),
        .rd_ok     (rd_ok)
    );

    // ==========================================================================
    // Write decode
    // ==========================================================================
    logic [31:0] bmask;
    logic [31:0] force_set;
    logic        wr_force;
    logic        wr_event;
    logic        wr_mask;
    logic        wr_ctl;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            bmask[i*8 +: 8] = {8{wr_strb[i]}};
        end
    end

    assign wr_force  = wr_stb && (wr_addr == ADDR_FORCE);
    assign wr_event  = wr_stb && (wr_addr == ADDR_EVENT);
    assign wr_mask   = wr_stb && (wr_addr == ADDR_IRQ_MASK);
    assign wr_ctl    = wr_stb && (wr_addr == ADDR_CONTROL);
    // Only ones act; reserved force bits are dropped here.
    assign force_set = wr_force ? (wr_data & bmask & FORCE_WMASK)
                                : 32'h0000_0000;
    assign wr_ok     = (wr_addr == ADDR_FORCE) || (wr_addr == ADDR_EVENT)
                    || (wr_addr == ADDR_IRQ_MASK)
                    || (wr_addr == ADDR_CONTROL)
                    || (wr_addr == ADDR_PRESENT);

    // ==========================================================================
    // Context reset
    // ==========================================================================
    logic pme_en_q;
    logic ctx_rst;

    // Context bits escape the bus reset while event signalling is on.
    assign ctx_rst = !global_reset_pin_n
                  || (!bus_reset_pin_n && !pme_en_q);

    always_ff @(posedge aclk) begin
        if (!aresetn || !global_reset_pin_n) begin
            pme_en_q <= 1'b0;
        end else if (wr_ctl && wr_strb[0]) begin
            pme_en_q <= wr_data[CTL_PME_EN];
        end
    end

    // ==========================================================================
    // Present-state context bits
    // ==========================================================================
    logic [3:0] volts_q;
    logic       badreq_q;
    logic       dataloss_q;
    logic       unrecog_q;
    logic       cardbus_q;
    logic       legacy_q;
    logic       powered_q;
    logic [1:0] detect_q;
    logic       badreq_hit;

    // Request asks for a supply that the card does not list.
    assign badreq_hit = power_request
                     && ((power_request_volts & ~volts_q) != 4'h0);

    always_ff @(posedge aclk) begin
        if (!aresetn || ctx_rst) begin
            volts_q   <= 4'h0;
            cardbus_q <= 1'b0;
            legacy_q  <= 1'b0;
        end else begin
            if (interrog_done) begin
                volts_q   <= interrog_volts;
                cardbus_q <= interrog_cardbus;
                legacy_q  <= interrog_legacy;
            end
            volts_q   <= (interrog_done ? interrog_volts : volts_q)
                       | force_set[BIT_YV:BIT_5V];
            cardbus_q <= (interrog_done ? interrog_cardbus : cardbus_q)
                       | force_set[BIT_CARDBUS];
            legacy_q  <= (interrog_done ? interrog_legacy : legacy_q)
                       | force_set[BIT_LEGACY];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || ctx_rst) begin
            badreq_q <= 1'b0;
        end else if (power_request || force_set[BIT_BADREQ]) begin
            badreq_q <= badreq_hit || force_set[BIT_BADREQ];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || ctx_rst) begin
            dataloss_q <= 1'b0;
        end else if ((card_removed && cycle_pending)
                     || force_set[BIT_DATALOSS]) begin
            dataloss_q <= 1'b1;
        end else if (interrog_done && interrog_valid) begin
            dataloss_q <= 1'b0;
        end
    end

    // Set by a bad insertion and held until a good card comes in.
    always_ff @(posedge aclk) begin
        if (!aresetn || ctx_rst) begin
            unrecog_q <= 1'b0;
        end else if (force_set[BIT_UNRECOG]) begin
            unrecog_q <= 1'b1;
        end else if (interrog_done && !interrog_valid && !unrecog_q) begin
            unrecog_q <= 1'b1;
        end else if (interrog_done && interrog_valid) begin
            unrecog_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || ctx_rst) begin
            powered_q <= 1'b0;
        end else if (power_done) begin
            powered_q <= power_on_result;
        end
    end

    // Frozen while interrogating so probing glitches stay hidden.
    always_ff @(posedge aclk) begin
        if (!aresetn || ctx_rst) begin
            detect_q <= DETECT_RESET[1:0];
        end else if (!interrogating) begin
            detect_q <= {detect_pin_b, detect_pin_a};
        end
    end

    // ==========================================================================
    // Power control and retest
    // ==========================================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            retest_start     <= 1'b0;
            power_ctl_enable <= 1'b1;
        end else begin
            retest_start <= force_set[BIT_RETEST];
            if (force_set[BIT_RETEST]) begin
                power_ctl_enable <= 1'b1;
            end else if (force_set[BIT_YV:BIT_5V] != 4'h0) begin
                power_ctl_enable <= 1'b0;
            end
        end
    end

    // ==========================================================================
    // Event status and interrupt
    // ==========================================================================
    logic [3:0] event_q;
    logic [3:0] mask_q;
    logic [3:0] ev_hit;

    // Hardware and forced sets win over a write-one clear.
    assign ev_hit = {power_change  || force_set[BIT_POWERED],
                     detect_b_change || force_set[BIT_DETECT_B],
                     detect_a_change || force_set[BIT_DETECT_A],
                     status_change_edge || force_set[BIT_STSCHG]};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_q <= EVENT_RESET;
        end else begin
            event_q <= (event_q & ~(wr_event && wr_strb[0]
                        ? wr_data[3:0] : 4'h0)) | ev_hit;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= 4'h0;
        end else if (wr_mask && wr_strb[0]) begin
            mask_q <= wr_data[3:0];
        end
    end

    assign irq = (event_q & mask_q) != 4'h0;

    // ==========================================================================
    // Read decode
    // ==========================================================================
    logic [31:0] present_word;

    always_comb begin
        present_word                = 32'h0000_0000;
        present_word[BIT_YV:BIT_5V] = volts_q;
        present_word[BIT_BADREQ]    = badreq_q;
        present_word[BIT_DATALOSS]  = dataloss_q;
        present_word[BIT_UNRECOG]   = unrecog_q;
        present_word[BIT_READY]     = card_ready_irq_pin;
        present_word[BIT_CARDBUS]   = cardbus_q;
        present_word[BIT_LEGACY]    = legacy_q;
        present_word[BIT_POWERED]   = powered_q;
        present_word[BIT_DETECT_B]  = detect_q[1];
        present_word[BIT_DETECT_A]  = detect_q[0];
        present_word[BIT_STSCHG]    = status_change_pin;
    end

    always_comb begin
        rd_ok   = 1'b1;
        rd_data = 32'h0000_0000;
        case (rd_addr)
            ADDR_PRESENT:  rd_data = present_word;
            ADDR_FORCE:    rd_data = 32'h0000_0000;
            ADDR_EVENT:    rd_data = {28'h0000000, event_q};
            ADDR_IRQ_MASK: rd_data = {28'h0000000, mask_q};
            ADDR_CONTROL:  rd_data = {31'h0, pme_en_q};
            default:       rd_ok   = 1'b0;
        endcase
    end

    // ==========================================================================
    // Checks
    // ==========================================================================
    AST_RETEST_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
        force_set[BIT_RETEST] |=> retest_start && power_ctl_enable)
        else $error("retest write did not start interrogation");
    AST_FORCE_CAP: assert property (@(posedge aclk) disable iff (!aresetn)
        (force_set[BIT_YV:BIT_5V] != 4'h0) && !force_set[BIT_RETEST]
        && !ctx_rst |=> !power_ctl_enable
        && ((volts_q & $past(force_set[BIT_YV:BIT_5V]))
            == $past(force_set[BIT_YV:BIT_5V])))
        else $error("capability force failed");
    AST_FORCE_EVENT: assert property (@(posedge aclk) disable iff (!aresetn)
        force_set[BIT_POWERED] |=> event_q[EV_POWER]
        && $stable(powered_q) || $past(power_done))
        else $error("power event force failed");
    AST_DETECT_FREEZE: assert property (@(posedge aclk) disable iff (!aresetn)
        interrogating && !ctx_rst |=> $stable(detect_q))
        else $error("detect bits moved during interrogation");
    AST_TYPE_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        !interrog_done && !force_set[BIT_CARDBUS] && !ctx_rst
        |=> $stable(cardbus_q))
        else $error("card type changed without interrogation");
    AST_DATALOSS: assert property (@(posedge aclk) disable iff (!aresetn)
        card_removed && cycle_pending && !ctx_rst |=> dataloss_q)
        else $error("data loss not flagged");
    AST_UNRECOG_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        unrecog_q && !(interrog_done && interrog_valid) && !ctx_rst
        |=> unrecog_q)
        else $error("unrecognized flag dropped early");
    AST_FORCE_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        s_rvalid && $past(s_arvalid && s_arready && s_araddr == ADDR_FORCE)
        |-> s_rdata == 32'h0000_0000)
        else $error("force register read nonzero");
    AST_BADREQ: assert property (@(posedge aclk) disable iff (!aresetn)
        power_request && !force_set[BIT_BADREQ] && !ctx_rst
        |=> badreq_q == $past(badreq_hit))
        else $error("invalid supply flag wrong");
    AST_CTX_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
        pme_en_q && global_reset_pin_n && powered_q && !power_done
        |=> powered_q)
        else $error("context bit lost under bus reset");

    COV_RETEST:  cover property (@(posedge aclk) force_set[BIT_RETEST]);
    COV_IRQ:     cover property (@(posedge aclk) irq);
    COV_BADREQ:  cover property (@(posedge aclk) badreq_q);
    COV_PMEKEEP: cover property (@(posedge aclk)
        pme_en_q && !bus_reset_pin_n && powered_q);
endmodule : sock_status_regs
`default_nettype wire
